//--- rtl/pasr_top.sv
/*
  pasr_top: samples the five address straps after reset, keeps the address in
  the phy control register, raises isolation for the all-zero address and then
  hands the shared pins back to the indicator drivers.
  assumes a management engine on the same clock issues register requests,
  and that each pad resolves level from led_out and led_oe_n.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - five straps select one of 32 addresses
// R2 - all-zero strap address raises isolation
// R3 - strap pin n latched into bit n
// R4 - active-high reset restores all register defaults
// R5 - every reset samples the straps again
// R6 - register access keeps working while isolated
// R7 - pins return to indicator drive after sampling
module pasr_top
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // shared strap/indicator pins
  input  wire logic [4:0]             pin_in,
  output logic      [4:0]             led_out,
  output logic      [4:0]             led_oe_n,
  // indicator sources from the phy core
  input  wire pasr_pkg::pasr_led_s    led_src,
  // register access
  input  wire pasr_pkg::pasr_reg_req_s reg_req,
  output logic      [15:0]            reg_rdata,
  output logic                        reg_rvalid,
  // status to the rest of the phy
  output logic      [4:0]             phy_addr,
  output logic                        isolate,
  output logic                        strap_done
);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic [4:0] strap_sync;

  pasr_strap_sync u_sync
  (
    .clk      (clk),
    .pin_in   (pin_in),
    .pin_sync (strap_sync)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pasr_pkg::pasr_state_e              state_r;
  pasr_pkg::pasr_state_e              state_nxt;
  logic [pasr_pkg::CNT_W-1:0]         cnt_r;
  logic [pasr_pkg::CNT_W-1:0]         cnt_nxt;
  logic [pasr_pkg::ADDR_W-1:0]        addr_r;
  logic [pasr_pkg::ADDR_W-1:0]        addr_nxt;
  logic [pasr_pkg::CTL_W-1:0]         ctl_r;
  logic [pasr_pkg::CTL_W-1:0]         ctl_nxt;
  logic                               done_r;
  logic                               done_nxt;
  logic                               iso_r;
  logic                               iso_nxt;
  logic [15:0]                        rdata_r;
  logic [15:0]                        rdata_nxt;
  logic                               rvalid_r;
  logic                               rvalid_nxt;
  logic [4:0]                         led_r;
  logic [4:0]                         led_nxt;
  logic [4:0]                         oe_n_r;
  logic [4:0]                         oe_n_nxt;
  logic                               latch_now;
  logic                               hit;

  // register hit decode, used for reads and writes
  function automatic logic reg_hit(input logic [4:0] a);
    reg_hit = (a == pasr_pkg::REG_PHY_CTRL);
  endfunction

  // read image of the control register
  function automatic logic [15:0] ctrl_image(input logic [pasr_pkg::CTL_W-1:0] c,
                                             input logic d,
                                             input logic [pasr_pkg::ADDR_W-1:0] a);
    ctrl_image = {c, d, a};
  endfunction

  assign hit       = reg_hit(reg_req.addr);
  assign latch_now = (state_r == pasr_pkg::ST_SAMPLE) && (cnt_r == pasr_pkg::SETTLE_LAST);

  // ---------------------------------------------------------------
  // sequencer: release pins, settle, latch, run
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = done_r;
    unique case (state_r)
      pasr_pkg::ST_SAMPLE:
      begin
        cnt_nxt = cnt_r + 5'h01;
        if (latch_now)
        begin
          state_nxt = pasr_pkg::ST_RUN;      // [R5]
          cnt_nxt   = pasr_pkg::CNT_RST;
          done_nxt  = 1'b1;
        end
      end
      pasr_pkg::ST_RUN:
      begin
        cnt_nxt = pasr_pkg::CNT_RST;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // control register and isolation
  // ---------------------------------------------------------------
  always_comb
  begin
    addr_nxt = addr_r;
    ctl_nxt  = ctl_r;
    if (reg_req.wr && hit)
    begin
      addr_nxt = reg_req.wdata[pasr_pkg::ADDR_LSB +: pasr_pkg::ADDR_W];
      ctl_nxt  = reg_req.wdata[pasr_pkg::CTL_LSB +: pasr_pkg::CTL_W];
    end
    // strap latch wins over a write to the address field in the same cycle
    if (latch_now)
    begin
      addr_nxt = strap_sync;                  // [R1] [R3]
    end
    iso_nxt = done_nxt && (addr_nxt == pasr_pkg::ISOLATE_ADDR);  // [R2]
  end

  // ---------------------------------------------------------------
  // register read port, independent of isolation
  // ---------------------------------------------------------------
  always_comb
  begin
    rvalid_nxt = reg_req.rd;                  // [R6]
    rdata_nxt  = 16'h0000;                    // unmapped reads as zero
    if (reg_req.rd && hit)
    begin
      rdata_nxt = ctrl_image(ctl_r, done_r, addr_r);
    end
  end

  // ---------------------------------------------------------------
  // pin drive: released while sampling, indicators afterwards
  // ---------------------------------------------------------------
  always_comb
  begin
    if (done_nxt)
    begin
      led_nxt  = led_src;                     // [R7]
      oe_n_nxt = pasr_pkg::PINS_DRIVEN;
    end
    else
    begin
      led_nxt  = 5'h00;
      oe_n_nxt = pasr_pkg::PINS_RELEASED;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r  <= pasr_pkg::ST_SAMPLE;        // [R4] [R5]
      cnt_r    <= pasr_pkg::CNT_RST;
      addr_r   <= pasr_pkg::CTRL_RST[pasr_pkg::ADDR_LSB +: pasr_pkg::ADDR_W];
      ctl_r    <= pasr_pkg::CTRL_RST[pasr_pkg::CTL_LSB +: pasr_pkg::CTL_W];
      done_r   <= 1'b0;
      iso_r    <= 1'b0;
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
      led_r    <= 5'h00;
      oe_n_r   <= pasr_pkg::PINS_RELEASED;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      addr_r   <= addr_nxt;
      ctl_r    <= ctl_nxt;
      done_r   <= done_nxt;
      iso_r    <= iso_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      led_r    <= led_nxt;
      oe_n_r   <= oe_n_nxt;
    end
  end

  // outputs straight from flops
  assign led_out    = led_r;
  assign led_oe_n   = oe_n_r;
  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign phy_addr   = addr_r;
  assign isolate    = iso_r;
  assign strap_done = done_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  addr_range_a: assert property ( // [R1]
    @(posedge clk) disable iff (rst)
    latch_now |=> (phy_addr == $past(strap_sync)) && strap_done)
    else $error("strap address not taken as phy address");

  isolate_zero_a: assert property ( // [R2]
    @(posedge clk) disable iff (rst)
    isolate == (strap_done && (phy_addr == pasr_pkg::ISOLATE_ADDR)))
    else $error("isolation does not follow zero address");

  strap_bits_a: assert property ( // [R3]
    @(posedge clk) disable iff (rst)
    reg_req.rd && hit |=> (reg_rdata[pasr_pkg::ADDR_LSB +: pasr_pkg::ADDR_W] == $past(phy_addr))
      && (reg_rdata[pasr_pkg::DONE_BIT] == $past(strap_done)))
    else $error("strap bits misplaced in control register");

  reset_default_a: assert property ( // [R4]
    @(posedge clk) disable iff (rst)
    $past(rst) |-> (ctl_r == pasr_pkg::CTRL_RST[pasr_pkg::CTL_LSB +: pasr_pkg::CTL_W])
      && !strap_done && !isolate && !reg_rvalid)
    else $error("register not at default after reset");

  resample_a: assert property ( // [R5]
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> (!strap_done throughout (##19 1'b1)) ##1 strap_done)
    else $error("straps not resampled over settle time after reset");

  mgmt_isolated_a: assert property ( // [R6]
    @(posedge clk) disable iff (rst)
    isolate && reg_req.rd && hit |=> reg_rvalid && (reg_rdata[4:0] == 5'h00)
      && reg_rdata[pasr_pkg::DONE_BIT])
    else $error("register read lost while isolated");

  led_release_a: assert property ( // [R7]
    @(posedge clk) disable iff (rst)
    (led_oe_n == (strap_done ? pasr_pkg::PINS_DRIVEN : pasr_pkg::PINS_RELEASED))
      and (strap_done |=> led_out == $past(led_src)))
    else $error("pin drive not matched to sampling phase");

endmodule

`default_nettype wire

//--- rtl/pasr_pkg.sv
/*
  pasr_pkg: constants and carrier types for the address strap and reset block.
  assumes a single 10 MHz clock and a 5-bit register address space.
*/
package pasr_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [4:0]  REG_PHY_CTRL   = 5'h19;   // phy_control_reg
  localparam int          ADDR_LSB       = 0;       // strap address field low bit
  localparam int          ADDR_W         = 5;       // strap address field width
  localparam int          DONE_BIT       = 5;       // read-only sampling-done flag
  localparam int          CTL_LSB        = 6;       // plain control field low bit
  localparam int          CTL_W          = 10;      // plain control field width
  localparam logic [15:0] CTRL_RST       = 16'h0000;
  localparam logic [4:0]  ISOLATE_ADDR   = 5'h00;   // address that isolates
  localparam logic [4:0]  PINS_RELEASED  = 5'h1F;   // all enables off (active low)
  localparam logic [4:0]  PINS_DRIVEN    = 5'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          STRAP_SETTLE_NS  = 2000;  // pins released before latch
  localparam int          STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W            = 5;
  localparam logic [4:0]  SETTLE_LAST      = 5'(STRAP_SETTLE_CYC - 1);
  localparam logic [4:0]  CNT_RST          = 5'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {ST_SAMPLE, ST_RUN} pasr_state_e;

  // indicator sources, bit n shares pin n with strap address bit n
  typedef struct packed {
    logic duplex_polarity_indicator;
    logic link_indicator;
    logic receive_indicator;
    logic transmit_indicator;
    logic collision_indicator;
  } pasr_led_s;

  // register access request from the management engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pasr_reg_req_s;

endpackage

//--- rtl/pasr_strap_sync.sv
/*
  pasr_strap_sync: two-flop synchroniser for the five strap/indicator pins.
  assumes the pin levels are asynchronous to clk; data pipeline, not reset,
  so the pins are tracked while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none

module pasr_strap_sync
(
  // clock
  input  wire logic       clk,
  // pins and synchronised levels
  input  wire logic [4:0] pin_in,
  output logic      [4:0] pin_sync
);

  // ---------------------------------------------------------------
  // two flops per pin
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      // first flop feeds only the second
      always_ff @(posedge clk)
      begin
        meta_r <= pin_in[g];
        sync_r <= meta_r;
      end
      assign pin_sync[g] = sync_r;
    end
  endgenerate

endmodule

`default_nettype wire

//--- verification/pasr_strap_model.sv
/*
  pasr_strap_model: pull resistors on the five shared strap/indicator pads.
  assumes led_oe_n is active low; a released pad rests at its resistor level.
*/
`timescale 1ns/1ps
`default_nettype none

module pasr_strap_model
(
  // resistor levels chosen by the bench
  input  wire logic [4:0] strap,
  // pad drive from the device
  input  wire logic [4:0] led_out,
  input  wire logic [4:0] led_oe_n,
  // resolved pad level
  output logic      [4:0] pin
);
  // ---------------------------------------------------------------
  // pad resolution
  // ---------------------------------------------------------------
  // a driven pad wins, a released pad falls back to its resistor
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      pin[i] = led_oe_n[i] ? strap[i] : led_out[i];
  end
endmodule

`default_nettype wire

//--- verification/phy_address_strap_reset_test.sv
/*
  phy_address_strap_reset_test: self-checking bench for pasr_top.
  assumes the pasr_pkg package and the pad model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module phy_address_strap_reset_test;
  logic                    clk;
  logic                    rst;
  logic [4:0]              strap;
  logic [4:0]              pin;
  logic [4:0]              led_out;
  logic [4:0]              led_oe_n;
  logic [4:0]              phy_addr;
  logic [15:0]             rdata;
  logic                    rvalid;
  logic                    isolate;
  logic                    done;
  pasr_pkg::pasr_led_s     led_src;
  pasr_pkg::pasr_reg_req_s req;
  pasr_pkg::pasr_reg_req_s latch_req = '0;  // request laid on the latch cycle, idle unless a test sets it
  int                      n_fail = 0;
  int                      checks_done = 0;
  int                      cyc = 0;
  logic [4:0]              tbl [5] = '{5'h00, 5'h1F, 5'h15, 5'h0A, 5'h01};

  // ---------------------------------------------------------------
  // device and pads
  // ---------------------------------------------------------------
  pasr_top u_dut (.clk(clk), .rst(rst), .pin_in(pin), .led_out(led_out), .led_oe_n(led_oe_n),
    .led_src(led_src), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .phy_addr(phy_addr),
    .isolate(isolate), .strap_done(done));
  pasr_strap_model u_pads (.strap(strap), .led_out(led_out), .led_oe_n(led_oe_n), .pin(pin));

  // clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hold reset, check defaults, then time the strap latch exactly
  task automatic do_reset(input logic [4:0] s, input int hold);
    @(posedge clk);
    strap <= s;
    rst   <= 1'b1;
    repeat (hold) @(posedge clk);
    #1;
    chk({phy_addr, isolate, done, rvalid, led_out}, 16'h0000);
    chk({rdata[10:0], led_oe_n}, 16'h001F);
    @(posedge clk);
    rst <= 1'b0;
    repeat (19) @(posedge clk);
    // the optional request is taken at the latch edge only
    req <= latch_req;
    #1;
    chk({led_oe_n, done}, 16'h003E);
    @(posedge clk);
    req <= '0;
    #1;
    chk(16'(phy_addr), 16'(s));
    chk({isolate, done, led_oe_n}, {9'h000, s == 5'h00, 6'h20});
    chk({rvalid, rdata[14:0]}, {latch_req.rd, 15'h0000});
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk({rvalid, rdata}, {1'b1, exp});
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst     = 1'b1;
    strap   = 5'h00;
    led_src = '0;
    req     = '0;
    foreach (tbl[i]) do_reset(tbl[i], i == 0 ? 11 : 2);
    $display("test strap_sweep done");
    do_reset(5'h00, 2);
    rd(5'h19, 16'h0020);
    rd(5'h03, 16'h0000);
    wr(5'h19, 16'hFFC5);
    rd(5'h19, 16'hFFE5);
    chk(16'(isolate), 16'h0000);
    wr(5'h19, 16'hFFC0);
    rd(5'h19, 16'hFFE0);
    chk(16'(isolate), 16'h0001);
    wr(5'h07, 16'h001F);
    rd(5'h19, 16'hFFE0);
    // write and read together in the latch cycle: straps win the address bits
    latch_req = '{wr: 1'b1, rd: 1'b1, addr: 5'h19, wdata: 16'hFFDF};
    do_reset(5'h0A, 2);
    latch_req = '0;
    rd(5'h19, 16'hFFEA);
    chk(16'(isolate), 16'h0000);
    $display("test register_access done");
    do_reset(5'h15, 2);
    rd(5'h19, 16'h0035);
    $display("test reset_defaults done");
    @(posedge clk);
    led_src <= 5'h13;
    repeat (2) @(posedge clk);
    #1;
    chk({led_out, pin}, 16'h0273);
    chk(16'(phy_addr), 16'h0015);
    $display("test indicator_drive done");
    wrap_up();
  end

  // cycle ceiling against a hang
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      wrap_up();
    end
  end
endmodule

`default_nettype wire
